/* bridge_rpc_pkg.sv */
package bridge_rpc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PWR = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;

  // control register fields
  localparam int CTRL_SEC_RST = 0;
  localparam int CTRL_CHIP_RST = 1;

  // status register fields
  localparam int STAT_SEC_RST = 0;
  localparam int STAT_SHIFT_DONE = 1;
  localparam int STAT_CLK_STOP = 2;
  localparam int STAT_PIN_RST = 3;
  localparam int STAT_CLK_EN_LSB = 4;

  // ----------------------------------------------------------------
  // power states, two-bit field
  // ----------------------------------------------------------------
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] PS_D3HOT = 2'h3;

  // ----------------------------------------------------------------
  // widths, reset values and timing counts (in primary clocks)
  // ----------------------------------------------------------------
  localparam int NUM_SEC_CLKS = 10;
  localparam int MASK_BITS = 16;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [4:0] ACCESS_HOLD_CLKS = 5'h10;
  localparam logic [4:0] SHIFT_CLKS = 5'h17;
  localparam logic [4:0] SHIFT_STROBE_FIRST = 5'h01;
  localparam logic [4:0] SHIFT_STROBE_LAST = 5'h10;
  localparam logic [4:0] MSK_SAMPLE_FIRST = 5'h03;
  localparam logic [4:0] MSK_SAMPLE_LAST = 5'h12;
  localparam int CHIP_CLR_MAX_CLKS = 20;

endpackage

/* level_sync.sv */
`timescale 1ns/1ns

// two-flop synchroniser; arst_n forces the output low at once,
// release is seen only after two clean edges
module level_sync (
  // clock and asynchronous clear
  input wire logic clk,
  input wire logic arst_n,
  // level in and out
  input wire logic d,
  output logic q
);

  logic meta_r;
  logic sync_r;

  // ------------------------------------------------------------
  // flop chain; the first stage feeds only the second
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule // level_sync

/* bridge_reset_power_control.sv */
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns

// Behaviour
// - D0 to D3hot write stops secondary clocks low if enable pin allows
// - writes requesting D1 or D2 are ignored; state stays as it was (D0 or D3hot)
// - D3hot to D0 re-enables clocks, internal chip reset, no secondary reset
// - power management events are never forwarded between the buses
// - primary reset tristates both buses and returns registers to defaults
// - primary reset edges are tolerated with no relation to any clock
// - no access during primary reset and for 16 clocks after release
// - secondary reset asserted whenever and as long as primary reset is
// - secondary reset bit asserts secondary reset until a write clears it
// - secondary reset pin, even from outside, tristates secondary side at once
// - during secondary reset control and grants float, data lines driven low
// - secondary reset discards all posted and delayed buffer contents
// - with the secondary reset bit set the registers remain accessible
// - chip reset bit resets everything, sets secondary reset bit, blocks access
// - after chip reset, hold secondary reset until bit cleared and mask shifted
// - chip reset bit clears itself within 20 clocks after the clearing write
// - clock mask shift takes 23 clocks; secondary reset held until done
// - shift control low one cycle to load, then high to shift, msb first
module bridge_reset_power_control (
  // clock and bus reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // primary side pins
  input wire logic primary_rst_n,
  input wire logic bus_power_clock_ctl_enable,
  output logic primary_oe_n,
  output logic config_ready,
  // secondary reset pin, open drain
  input wire logic sec_rst_pin_i_n,
  output logic sec_rst_pin_o_n,
  output logic sec_rst_pin_oe_n,
  // secondary interface control
  output logic [9:0] secondary_clock_outputs,
  output logic secondary_ctl_oe_n,
  output logic secondary_park_low,
  output logic buffer_flush,
  // clock mask shift register
  input wire logic clock_mask_serial_in,
  output logic shift_ctl_o,
  output logic shift_ctl_oe_n,
  output logic shift_strobe_o,
  output logic shift_strobe_oe_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] hold_cnt;
    logic accessible;
    logic dphase;
    logic dwrite;
    logic [7:0] daddr;
    logic [31:0] rdata;
    logic sec_rst_bit;
    logic chip_rst_bit;
    logic [1:0] pstate;
    logic clk_stop;
    logic soft_rst;
    logic shifting;
    logic shift_done;
    logic [4:0] shift_cnt;
    logic [15:0] mask_shift;
    logic [15:0] mask;
    logic [9:0] clk_en;
  } state_t;

  localparam state_t STATE_RST = '{
    hold_cnt: 5'h00, accessible: 1'b0, dphase: 1'b0, dwrite: 1'b0,
    daddr: 8'h00, rdata: 32'h0000_0000, sec_rst_bit: 1'b0,
    chip_rst_bit: 1'b0, pstate: bridge_rpc_pkg::PS_D0, clk_stop: 1'b0,
    soft_rst: 1'b0, shifting: 1'b0, shift_done: 1'b0, shift_cnt: 5'h00,
    mask_shift: 16'h0000, mask: bridge_rpc_pkg::MASK_RESET,
    clk_en: 10'h000
  };

  state_t s_r;
  state_t s_nxt;

  logic prst_released;
  logic prst_active;
  logic sec_pin_released;
  logic sec_pin_active;
  logic bus_power_clock_ctl_enable_s;
  logic msk_s;
  logic sec_rst_int;
  logic sec_any;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // assert is immediate through the async clear, release is clean
  level_sync prst_sync_u (
    .clk(hclk),
    .arst_n(hresetn & primary_rst_n),
    .d(1'b1),
    .q(prst_released)
  );

  // an outside driver may pull the secondary reset pin at any time
  level_sync spin_sync_u (
    .clk(hclk),
    .arst_n(hresetn & sec_rst_pin_i_n),
    .d(1'b1),
    .q(sec_pin_released)
  );

  level_sync bus_power_clock_ctl_enable_sync_u (
    .clk(hclk),
    .arst_n(hresetn),
    .d(bus_power_clock_ctl_enable),
    .q(bus_power_clock_ctl_enable_s)
  );

  level_sync msk_sync_u (
    .clk(hclk),
    .arst_n(hresetn),
    .d(clock_mask_serial_in),
    .q(msk_s)
  );

  assign prst_active = ~prst_released;
  assign sec_pin_active = ~sec_pin_released;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // slot clock runs when a card is present (either bit low)
  function automatic logic slot_clk_en(input logic [1:0] prsnt);
    return ~(prsnt[1] & prsnt[0]);
  endfunction

  function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] a,
                                           input logic rst_out, input logic pin_rst);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      bridge_rpc_pkg::ADDR_CTRL: begin
        v[bridge_rpc_pkg::CTRL_SEC_RST] = s.sec_rst_bit;
        v[bridge_rpc_pkg::CTRL_CHIP_RST] = s.chip_rst_bit;
      end
      bridge_rpc_pkg::ADDR_PWR: v[1:0] = s.pstate;
      bridge_rpc_pkg::ADDR_STAT: begin
        v[bridge_rpc_pkg::STAT_SEC_RST] = rst_out;
        v[bridge_rpc_pkg::STAT_SHIFT_DONE] = s.shift_done;
        v[bridge_rpc_pkg::STAT_CLK_STOP] = s.clk_stop;
        v[bridge_rpc_pkg::STAT_PIN_RST] = pin_rst;
        v[bridge_rpc_pkg::STAT_CLK_EN_LSB +: 10] = s.clk_en;
      end
      bridge_rpc_pkg::ADDR_MASK: v[15:0] = s.mask;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic take;
    logic [1:0] ps_req;
    take = 1'b0;
    ps_req = hwdata[1:0];
    s_nxt = s_r;
    s_nxt.soft_rst = 1'b0;
    if (prst_active) begin
      s_nxt = STATE_RST;
    end else begin
      // inaccessible window after release
      if (s_r.hold_cnt != bridge_rpc_pkg::ACCESS_HOLD_CLKS) begin
        s_nxt.hold_cnt = s_r.hold_cnt + 5'h01;
      end
      s_nxt.accessible = s_r.accessible |
        (s_r.hold_cnt == bridge_rpc_pkg::ACCESS_HOLD_CLKS - 5'h01);

      // mask shift starts whenever secondary reset stands without a mask
      if (!s_r.shifting && !s_r.shift_done) begin
        s_nxt.shifting = 1'b1;
        s_nxt.shift_cnt = 5'h00;
      end else if (s_r.shifting) begin
        s_nxt.shift_cnt = s_r.shift_cnt + 5'h01;
        // two-flop latency on the serial input shifts the sample window
        if (s_r.shift_cnt >= bridge_rpc_pkg::MSK_SAMPLE_FIRST &&
            s_r.shift_cnt <= bridge_rpc_pkg::MSK_SAMPLE_LAST) begin
          s_nxt.mask_shift = {s_r.mask_shift[14:0], msk_s};
        end
        if (s_r.shift_cnt == bridge_rpc_pkg::SHIFT_CLKS - 5'h01) begin
          s_nxt.shifting = 1'b0;
          s_nxt.shift_done = 1'b1;
          s_nxt.mask = s_r.mask_shift;
        end
      end

      // chip reset finishes once software released the secondary bus
      if (s_r.chip_rst_bit && !s_r.sec_rst_bit && s_r.shift_done) begin
        s_nxt.chip_rst_bit = 1'b0;
      end

      // address phase; the secondary reset bit does not block it
      take = hsel & hready & htrans[1] & s_r.accessible;
      if (hready) begin
        s_nxt.dphase = take;
        s_nxt.dwrite = hwrite;
        s_nxt.daddr = {haddr[7:2], 2'b00};
        s_nxt.rdata = 32'h0000_0000;
        if (take && !hwrite &&
            (!s_r.chip_rst_bit || haddr[7:2] == 6'h00)) begin
          s_nxt.rdata = read_reg(s_r, {haddr[7:2], 2'b00}, sec_rst_int,
                                 sec_pin_active);
        end
      end

      // data phase write commit
      if (s_r.dphase && s_r.dwrite) begin
        unique case (s_r.daddr)
          bridge_rpc_pkg::ADDR_CTRL: begin
            if (hwdata[bridge_rpc_pkg::CTRL_CHIP_RST]) begin
              s_nxt = STATE_RST;
              s_nxt.hold_cnt = bridge_rpc_pkg::ACCESS_HOLD_CLKS;
              s_nxt.accessible = 1'b1;
              s_nxt.chip_rst_bit = 1'b1;
              s_nxt.sec_rst_bit = 1'b1;
            end else begin
              s_nxt.sec_rst_bit = hwdata[bridge_rpc_pkg::CTRL_SEC_RST];
            end
          end
          bridge_rpc_pkg::ADDR_PWR: begin
            if (!s_r.chip_rst_bit) begin
              if (s_r.pstate == bridge_rpc_pkg::PS_D0 &&
                  ps_req == bridge_rpc_pkg::PS_D3HOT) begin
                s_nxt.pstate = bridge_rpc_pkg::PS_D3HOT;
                s_nxt.clk_stop = bus_power_clock_ctl_enable_s;
              end else if (s_r.pstate == bridge_rpc_pkg::PS_D3HOT &&
                           ps_req == bridge_rpc_pkg::PS_D0) begin
                // internal reset only; the mask survives, no re-shift
                s_nxt.pstate = bridge_rpc_pkg::PS_D0;
                s_nxt.clk_stop = 1'b0;
                s_nxt.sec_rst_bit = 1'b0;
                s_nxt.soft_rst = 1'b1;
              end
              // d1 and d2 requests fall through untouched
            end
          end
          bridge_rpc_pkg::ADDR_MASK: begin
            if (!s_r.chip_rst_bit && s_r.shift_done) begin
              s_nxt.mask = hwdata[15:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    // clock enables, registered so the gate controls are glitch free
    for (int i = 0; i < 4; i++) begin
      s_nxt.clk_en[i] = slot_clk_en(s_r.mask[2*i +: 2]) & ~s_r.clk_stop;
    end
    s_nxt.clk_en[8:4] = ~s_r.mask[12:8] & {5{~s_r.clk_stop}};
    s_nxt.clk_en[9] = ~s_r.mask[13] & ~s_r.clk_stop;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // held while the mask is missing, covers power-up and chip reset
  assign sec_rst_int = prst_active | s_r.sec_rst_bit | ~s_r.shift_done;
  assign sec_any = sec_rst_int | sec_pin_active | s_r.chip_rst_bit;

  // bus answers; wait states stand in for refusal while not accessible
  assign hreadyout = s_r.accessible & ~prst_active;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;

  assign primary_oe_n = prst_active | s_r.chip_rst_bit;
  assign config_ready = s_r.accessible & ~s_r.chip_rst_bit & ~prst_active;

  // open drain: pull low only while asserting
  assign sec_rst_pin_o_n = 1'b0;
  assign sec_rst_pin_oe_n = ~sec_rst_int;

  // no event path exists between the buses here by design
  assign secondary_clock_outputs = s_r.clk_en;
  assign secondary_ctl_oe_n = sec_any;
  assign secondary_park_low = sec_any;
  assign buffer_flush = sec_any | s_r.soft_rst;

  // external shift register control, released when the shift ends
  assign shift_ctl_o = ~(s_r.shifting & (s_r.shift_cnt == 5'h00));
  assign shift_ctl_oe_n = ~s_r.shifting;
  assign shift_strobe_o = s_r.shifting &
    (s_r.shift_cnt >= bridge_rpc_pkg::SHIFT_STROBE_FIRST) &
    (s_r.shift_cnt <= bridge_rpc_pkg::SHIFT_STROBE_LAST);
  assign shift_strobe_oe_n = ~s_r.shifting;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  localparam int CHIP_CLR_BOUND = 20;

  pwr_ignore_a: assert property (
    s_r.dphase && s_r.dwrite && s_r.daddr == bridge_rpc_pkg::ADDR_PWR &&
    !prst_active && (hwdata[1:0] == bridge_rpc_pkg::PS_D1 ||
    hwdata[1:0] == bridge_rpc_pkg::PS_D2) |=> $stable(s_r.pstate)
  ) else $error("d1 or d2 request changed the power state");

  clk_stop_a: assert property (
    s_r.dphase && s_r.dwrite && s_r.daddr == bridge_rpc_pkg::ADDR_PWR &&
    !prst_active && !s_r.chip_rst_bit && s_r.pstate == bridge_rpc_pkg::PS_D0 &&
    hwdata[1:0] == bridge_rpc_pkg::PS_D3HOT && bus_power_clock_ctl_enable_s
    |=> ##1 secondary_clock_outputs == 10'h000
  ) else $error("secondary clocks still running in d3hot");

  d3_wake_a: assert property (
    s_r.dphase && s_r.dwrite && s_r.daddr == bridge_rpc_pkg::ADDR_PWR &&
    !prst_active && !s_r.chip_rst_bit && s_r.pstate == bridge_rpc_pkg::PS_D3HOT &&
    hwdata[1:0] == bridge_rpc_pkg::PS_D0 && s_r.shift_done && !sec_pin_active
    |=> s_r.soft_rst && buffer_flush && !s_r.clk_stop && sec_rst_pin_oe_n
  ) else $error("wake from d3hot did not reset internally");

  prst_hold_a: assert property (
    prst_active |-> !sec_rst_pin_oe_n && primary_oe_n && secondary_ctl_oe_n
  ) else $error("primary reset did not tristate and reset the buses");

  access_hold_a: assert property (
    $fell(prst_active) |-> (!hreadyout)[*8] ##1 (!hreadyout)[*8] ##1 hreadyout
  ) else $error("access window after primary reset is not 16 clocks");

  sec_bit_a: assert property (
    s_r.sec_rst_bit && !prst_active |-> !sec_rst_pin_oe_n && secondary_park_low
  ) else $error("secondary reset bit set but reset not driven");

  pin_tri_a: assert property (
    sec_pin_active |-> secondary_ctl_oe_n && secondary_park_low && buffer_flush
  ) else $error("secondary pin reset did not float the secondary side");

  chip_set_a: assert property (
    s_r.dphase && s_r.dwrite && s_r.daddr == bridge_rpc_pkg::ADDR_CTRL &&
    !prst_active && hwdata[bridge_rpc_pkg::CTRL_CHIP_RST]
    |=> s_r.sec_rst_bit && s_r.chip_rst_bit && !config_ready && primary_oe_n
  ) else $error("chip reset write did not take effect");

  chip_clear_a: assert property (
    s_r.chip_rst_bit && !s_r.sec_rst_bit && s_r.shift_done && !prst_active
    |-> ##[1:CHIP_CLR_BOUND] !s_r.chip_rst_bit
  ) else $error("chip reset bit did not clear in time");

  mask_hold_a: assert property (
    !s_r.shift_done |-> !sec_rst_pin_oe_n
  ) else $error("secondary reset released before the mask shift");

  shift_len_a: assert property (
    $rose(s_r.shifting) && !prst_active |-> ##23 (s_r.shift_done && !s_r.shifting)
  ) else $error("mask shift did not take 23 clocks");

  load_ctl_a: assert property (
    $rose(s_r.shifting) && !prst_active |-> !shift_ctl_o ##1 shift_ctl_o
  ) else $error("shift control did not load then shift");

endmodule // bridge_reset_power_control

/* mask_source.sv */
`timescale 1ns/1ns

// ----------------------------------------------------------------
// far side: external clock mask shifter and secondary reset wire
// ----------------------------------------------------------------
module mask_source (
  // clock and preset mask
  input wire logic hclk,
  input wire logic [15:0] mask_val,
  // shift control from the bridge
  input wire logic shift_ctl_o,
  input wire logic shift_ctl_oe_n,
  input wire logic shift_strobe_o,
  input wire logic shift_strobe_oe_n,
  output logic clock_mask_serial_in,
  // secondary reset wire, pulled up
  input wire logic sec_rst_pin_o_n,
  input wire logic sec_rst_pin_oe_n,
  input wire logic ext_rst_n,
  output logic sec_rst_wire_n
);
  logic [15:0] sr_r = 16'h0000;

  // parallel load on low control, then msb leaves first on each strobe
  always_ff @(posedge hclk) begin
    if (!shift_ctl_oe_n && !shift_ctl_o) begin
      sr_r <= mask_val;
    end else if (!shift_strobe_oe_n && shift_strobe_o) begin
      sr_r <= {sr_r[14:0], 1'b0};
    end
  end
  assign clock_mask_serial_in = sr_r[15];

  // wired-and: any party may pull low, pull-up otherwise
  assign sec_rst_wire_n = ext_rst_n & (sec_rst_pin_oe_n | sec_rst_pin_o_n);
endmodule // mask_source

/* bridge_reset_power_control_tb.sv */
`timescale 1ns/1ns

module bridge_reset_power_control_tb;
  logic hclk, hresetn, hsel, hwrite, primary_rst_n, bus_power_clock_ctl_enable, ext_rst_n;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans;
  logic [15:0] mask_val;
  logic [9:0] secondary_clock_outputs;
  logic hreadyout, primary_oe_n, config_ready, sec_rst_pin_i_n, sec_rst_pin_o_n;
  logic sec_rst_pin_oe_n, secondary_ctl_oe_n, secondary_park_low, buffer_flush;
  logic clock_mask_serial_in, shift_ctl_o, shift_ctl_oe_n, shift_strobe_o, shift_strobe_oe_n;
  logic sec_seen, flush_seen;
  int mismatches, check_count, ctrl_m, pwr_m, mask_m, n;

  bridge_reset_power_control dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
    .primary_rst_n, .bus_power_clock_ctl_enable, .primary_oe_n, .config_ready,
    .sec_rst_pin_i_n, .sec_rst_pin_o_n, .sec_rst_pin_oe_n, .secondary_clock_outputs,
    .secondary_ctl_oe_n, .secondary_park_low, .buffer_flush, .clock_mask_serial_in,
    .shift_ctl_o, .shift_ctl_oe_n, .shift_strobe_o, .shift_strobe_oe_n);

  mask_source msrc (.hclk, .mask_val, .shift_ctl_o, .shift_ctl_oe_n, .shift_strobe_o,
    .shift_strobe_oe_n, .clock_mask_serial_in, .sec_rst_pin_o_n, .sec_rst_pin_oe_n,
    .ext_rst_n, .sec_rst_wire_n(sec_rst_pin_i_n));

  // ----------------------------------------------------------------
  // clock, watchdog, event sniffer
  // ----------------------------------------------------------------
  always #5 hclk = ~hclk;

  // a hung handshake would otherwise stall the run forever
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    stop_test();
  end

  // catches one-cycle pulses that a bus read would miss
  always @(negedge hclk) begin
    if (sec_rst_pin_i_n === 1'b0) sec_seen = 1'b1;
    if (buffer_flush === 1'b1) flush_seen = 1'b1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // single ahb transfer; ready judged in the low half, where it is settled
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    rdv = hrdata;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
    if (a == bridge_rpc_pkg::ADDR_CTRL) ctrl_m = d & 3;
    if (a == bridge_rpc_pkg::ADDR_PWR && (d[1:0] == 2'h0 || d[1:0] == 2'h3)) pwr_m = d[1:0];
    if (a == bridge_rpc_pkg::ADDR_MASK) mask_m = d[15:0];
  endtask

  task automatic rd(input logic [7:0] a);
    int e;
    xfer(a, 1'b0, 32'h00000000);
    e = (a == bridge_rpc_pkg::ADDR_CTRL) ? ctrl_m : (a == bridge_rpc_pkg::ADDR_PWR) ? pwr_m :
        (a == bridge_rpc_pkg::ADDR_MASK) ? mask_m : 0;
    chk("read", rdv, e);
  endtask

  // wait for access, then for the mask shift; mask comes from the far side
  task automatic wait_up();
    n = 0;
    while (hreadyout !== 1'b1 && n < 40) begin
      @(posedge hclk);
      #1 n++;
    end
    chk("sec_held", sec_rst_pin_oe_n, 0);
    n = 0;
    do begin
      xfer(bridge_rpc_pkg::ADDR_STAT, 1'b0, 32'h00000000);
      n++;
    end while (rdv[bridge_rpc_pkg::STAT_SHIFT_DONE] !== 1'b1 && n < 40);
    mask_m = mask_val;
  endtask

  function automatic logic [31:0] cexp(input int m);
    logic [9:0] c;
    for (int i = 0; i < 4; i++) c[i] = ~(m[2*i] & m[2*i+1]);
    c[8:4] = ~m[12:8];
    c[9] = ~m[13];
    return {22'h000000, c};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    primary_rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    bus_power_clock_ctl_enable = 1'b1;
    ext_rst_n = 1'b1;
    {mismatches, check_count, ctrl_m, pwr_m, mask_m} = '0;
    void'($urandom(35840));
    mask_val = 16'($urandom);
    repeat (2) @(posedge hclk);
    #1 chk("rst_pins", {primary_oe_n, sec_rst_pin_oe_n, secondary_ctl_oe_n,
      secondary_park_low, hreadyout}, 32'h16);
    @(posedge hclk);
    hresetn <= 1'b1;
    primary_rst_n <= 1'b1;
    n = 0;
    while (hreadyout !== 1'b1 && n < 40) begin
      @(posedge hclk);
      #1 n++;
    end
    chk("hold_clks", n, 18);
    wait_up();
    @(negedge hclk);
    chk("sec_free", {sec_rst_pin_i_n, primary_oe_n}, 32'h2);
    chk("clk_en", secondary_clock_outputs, cexp(mask_m));
    rd(bridge_rpc_pkg::ADDR_MASK);
    wr(8'h10, $urandom);
    rd(8'h10);
    for (int c = 1; c < 3; c++) begin
      wr(bridge_rpc_pkg::ADDR_PWR, c);
      rd(bridge_rpc_pkg::ADDR_PWR);
    end
    wr(bridge_rpc_pkg::ADDR_MASK, $urandom);
    rd(bridge_rpc_pkg::ADDR_MASK);
    // clock stop in the deep state, then return to full power
    wr(bridge_rpc_pkg::ADDR_PWR, 3);
    rd(bridge_rpc_pkg::ADDR_PWR);
    chk("clk_stop", secondary_clock_outputs, 0);
    sec_seen = 1'b0;
    flush_seen = 1'b0;
    wr(bridge_rpc_pkg::ADDR_PWR, 0);
    repeat (3) @(posedge hclk);
    chk("d0_events", {sec_seen, flush_seen}, 32'h1);
    chk("clk_back", secondary_clock_outputs, cexp(mask_m));
    rd(bridge_rpc_pkg::ADDR_MASK);
    // enable pin low keeps clocks running in the deep state
    bus_power_clock_ctl_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    wr(bridge_rpc_pkg::ADDR_PWR, 3);
    chk("clk_kept", secondary_clock_outputs, cexp(mask_m));
    wr(bridge_rpc_pkg::ADDR_PWR, 0);
    bus_power_clock_ctl_enable <= 1'b1;
    // secondary reset bit
    wr(bridge_rpc_pkg::ADDR_CTRL, 1);
    rd(bridge_rpc_pkg::ADDR_CTRL);
    chk("sbit_on", {sec_rst_pin_i_n, secondary_ctl_oe_n, secondary_park_low,
      buffer_flush}, 32'h7);
    wr(bridge_rpc_pkg::ADDR_CTRL, 0);
    // pin release passes the two-flop synchroniser before the side un-floats
    repeat (3) @(negedge hclk);
    chk("sbit_off", {sec_rst_pin_i_n, secondary_ctl_oe_n, secondary_park_low}, 32'h4);
    // secondary reset from an outside source
    @(posedge hclk);
    ext_rst_n <= 1'b0;
    repeat (3) @(negedge hclk);
    chk("ext_rst", {secondary_ctl_oe_n, secondary_park_low, buffer_flush}, 32'h7);
    xfer(bridge_rpc_pkg::ADDR_STAT, 1'b0, 32'h00000000);
    chk("pin_seen", rdv[bridge_rpc_pkg::STAT_PIN_RST], 1);
    ext_rst_n <= 1'b1;
    // chip reset bit
    mask_val = 16'($urandom);
    wr(bridge_rpc_pkg::ADDR_CTRL, 2);
    {ctrl_m, pwr_m, mask_m} = {32'd3, 32'd0, 32'd0};
    rd(bridge_rpc_pkg::ADDR_CTRL);
    rd(bridge_rpc_pkg::ADDR_PWR);
    chk("chip_pins", {config_ready, sec_rst_pin_i_n}, 32'h0);
    repeat (30) @(posedge hclk);
    chk("chip_hold", sec_rst_pin_i_n, 0);
    wr(bridge_rpc_pkg::ADDR_CTRL, 0);
    repeat (20) @(posedge hclk);
    rd(bridge_rpc_pkg::ADDR_CTRL);
    mask_m = mask_val;
    rd(bridge_rpc_pkg::ADDR_MASK);
    chk("chip_done", {config_ready, sec_rst_pin_i_n}, 32'h3);
    // primary reset in mid-run, off the clock edge
    wr(bridge_rpc_pkg::ADDR_PWR, 3);
    @(posedge hclk);
    #3 primary_rst_n <= 1'b0;
    #1 chk("prst_now", {primary_oe_n, hreadyout, sec_rst_pin_oe_n}, 32'h4);
    repeat (3) @(posedge hclk);
    #4 primary_rst_n <= 1'b1;
    {ctrl_m, pwr_m} = '0;
    wait_up();
    rd(bridge_rpc_pkg::ADDR_PWR);
    rd(bridge_rpc_pkg::ADDR_MASK);
    stop_test();
  end
endmodule // bridge_reset_power_control_tb
